// ### logic/rcf_top.sv
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
// What this block does
// - Pin reset sets the pin reset flag
// - Soft bit enables watchdog; fuse forces on
// - PWM match request sets its flag
// - PWM flag reads back, writable, resets zero
// - Unused flag-register bits ignore writes, read zero
module rcf_top
  import rcf_pkg::*;
(
  input  wire logic                  I_MCLK,
  input  wire logic                  I_NRST,
  input  wire rcf_pkg::rcf_evt_t     I_EVT,
  input  wire logic                  I_WDT_FUSE_EN,
  output logic                       O_WDT_EN,
  output logic                       O_IRQ,
  input  wire logic [rcf_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic                  I_AWVALID,
  output logic                       O_AWREADY,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic [3:0]            I_WSTRB,
  input  wire logic                  I_WVALID,
  output logic                       O_WREADY,
  output logic [1:0]                 O_BRESP,
  output logic                       O_BVALID,
  input  wire logic                  I_BREADY,
  input  wire logic [rcf_pkg::ADDR_W-1:0] I_ARADDR,
  input  wire logic                  I_ARVALID,
  output logic                       O_ARREADY,
  output logic [1:0]                 O_RRESP,
  output logic [31:0]                O_RDATA,
  output logic                       O_RVALID,
  input  wire logic                  I_RREADY
);
  import rcf_pkg::*;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [15:0]       reset_cause_control;
  logic [15:0]       interrupt_flag_status_three;
  wire  [N_EVT-1:0]  irq_status;
  wire  [N_EVT-1:0]  irq_mask;
  logic [15:0]       wmask;
  logic [15:0]       next_rcc;
  logic [15:0]       next_interrupt_flag_status_three;
  wire  [N_EVT-1:0]  evt_vec;
  logic              aw_ready;
  logic              w_ready;
  logic              ar_ready;
  logic [15:0]       rcc_set;
  logic              rcc_wr;
  logic              interrupt_flag_status_three_wr;
  logic              sts_wr;
  logic              msk_wr;

  // Readies are decoded from slave flops, so they never wait on a valid
  rcf_axil_slave rcf_axil_slave_inst (
    .i_clk     (I_MCLK),
    .i_nrst    (I_NRST),
    .i_awaddr  (I_AWADDR),
    .i_awvalid (I_AWVALID),
    .o_awready (aw_ready),
    .i_wdata   (I_WDATA),
    .i_wstrb   (I_WSTRB),
    .i_wvalid  (I_WVALID),
    .o_wready  (w_ready),
    .o_bresp   (O_BRESP),
    .o_bvalid  (O_BVALID),
    .i_bready  (I_BREADY),
    .i_araddr  (I_ARADDR),
    .i_arvalid (I_ARVALID),
    .o_arready (ar_ready),
    .o_rresp   (O_RRESP),
    .o_rdata   (O_RDATA),
    .o_rvalid  (O_RVALID),
    .i_rready  (I_RREADY),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_ok   (wr_ok),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );
  // Readies derive from flops only (held flags and valid outputs)
  assign O_AWREADY = aw_ready;
  assign O_WREADY  = w_ready;
  assign O_ARREADY = ar_ready;

  assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign wr_ok = (wr_addr == RESET_CAUSE_CONTROL_ADDR)
              || (wr_addr == INTERRUPT_FLAG_STATUS_THREE_ADDR)
              || (wr_addr == IRQ_STATUS_ADDR)
              || (wr_addr == IRQ_MASK_ADDR);
  assign rd_ok = (rd_addr == RESET_CAUSE_CONTROL_ADDR)
              || (rd_addr == INTERRUPT_FLAG_STATUS_THREE_ADDR)
              || (rd_addr == IRQ_STATUS_ADDR)
              || (rd_addr == IRQ_MASK_ADDR);

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      RESET_CAUSE_CONTROL_ADDR: rd_data[15:0] = reset_cause_control;
      INTERRUPT_FLAG_STATUS_THREE_ADDR:
        rd_data[15:0] = interrupt_flag_status_three;
      IRQ_STATUS_ADDR: rd_data[N_EVT-1:0] = irq_status;
      IRQ_MASK_ADDR: rd_data[N_EVT-1:0] = irq_mask;
      default: rd_data = '0;
    endcase
  end

  assign rcc_wr  = wr_en && (wr_addr == RESET_CAUSE_CONTROL_ADDR);
  assign interrupt_flag_status_three_wr = wr_en && (wr_addr == INTERRUPT_FLAG_STATUS_THREE_ADDR);
  assign sts_wr  = wr_en && (wr_addr == IRQ_STATUS_ADDR) && wr_strb[0];
  assign msk_wr  = wr_en && (wr_addr == IRQ_MASK_ADDR) && wr_strb[0];

  // Hardware causes gathered in one vector so they can be ORed in last
  always_comb begin
    rcc_set            = '0;
    rcc_set[POS_PIN]   = I_EVT.pin_reset;
    rcc_set[POS_SWR]   = I_EVT.soft_reset;
    rcc_set[POS_WATCHDOG_TIMEOUT_FLAG]  = I_EVT.wdt_timeout;
    rcc_set[POS_SLEEP] = I_EVT.woke_sleep;
    rcc_set[POS_IDLE]  = I_EVT.woke_idle;
  end

  // Hardware events are applied after the software write so a set wins
  always_comb begin
    next_rcc = reset_cause_control;
    if (rcc_wr) begin
      // Plain store, no reset is requested from here
      next_rcc = (reset_cause_control & ~wmask)
               | (wr_data[15:0] & wmask & RCC_IMPL_MASK);
    end
    next_rcc = next_rcc | rcc_set;
  end

  // Only the match flag is stored; writes to other positions fall away
  always_comb begin
    next_interrupt_flag_status_three = interrupt_flag_status_three;
    if (interrupt_flag_status_three_wr) begin
      next_interrupt_flag_status_three = (interrupt_flag_status_three & ~wmask)
                | (wr_data[15:0] & wmask & INTERRUPT_FLAG_STATUS_THREE_IMPL_MASK);
    end
    if (I_EVT.pwm_match) next_interrupt_flag_status_three[POS_PWM_MATCH] = 1'b1;
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      reset_cause_control <= RCC_RESET;
    end else begin
      reset_cause_control <= next_rcc;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      interrupt_flag_status_three <= INTERRUPT_FLAG_STATUS_THREE_RESET;
    end else begin
      interrupt_flag_status_three <= next_interrupt_flag_status_three & INTERRUPT_FLAG_STATUS_THREE_IMPL_MASK;
    end
  end

  assign evt_vec[EVT_PIN] = I_EVT.pin_reset;
  assign evt_vec[EVT_SWR] = I_EVT.soft_reset;
  assign evt_vec[EVT_PWM] = I_EVT.pwm_match;

  // Sticky status, write one to clear; a new event beats the clear
  // One status flop and one mask flop per event, built alike
  for (genvar e = 0; e < N_EVT; e++) begin : g_evt
    logic sts_q;
    logic msk_q;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
        sts_q <= EVT_ZERO[e];
      end else if (evt_vec[e]) begin
        sts_q <= 1'b1;
      end else if (sts_wr && wr_data[e]) begin
        sts_q <= 1'b0;
      end
    end

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
        msk_q <= EVT_ZERO[e];
      end else if (msk_wr) begin
        msk_q <= wr_data[e];
      end
    end

    // Bits meet on nets, so each one keeps a single driver
    assign irq_status[e] = sts_q;
    assign irq_mask[e]   = msk_q;
  end

  // Level interrupt, one cycle behind the status and mask flops
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_status & irq_mask);
    end
  end

  // Fuse is ORed in here so software can never switch the watchdog off while the fuse is set
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WDT_EN <= 1'b0;
    end else begin
      O_WDT_EN <= reset_cause_control[POS_WDT_SOFT]
                  || I_WDT_FUSE_EN;
    end
  end
endmodule
`default_nettype wire

// ### logic/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] RESET_CAUSE_CONTROL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] INTERRUPT_FLAG_STATUS_THREE_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 4'hc;

  // Reset cause control field positions
  localparam int unsigned POS_POR = 0;
  localparam int unsigned POS_BOR = 1;
  localparam int unsigned POS_IDLE = 2;
  localparam int unsigned POS_SLEEP = 3;
  localparam int unsigned POS_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int unsigned POS_WDT_SOFT = 5;
  localparam int unsigned POS_SWR = 6;
  localparam int unsigned POS_PIN = 7;
  localparam int unsigned POS_REGULATOR_SLEEP_STANDBY = 8;
  localparam int unsigned POS_CM = 9;
  localparam int unsigned POS_IOPUWR = 14;
  localparam int unsigned POS_TRAPR = 15;
  localparam logic [15:0] RCC_IMPL_MASK = 16'hc3ff;
  localparam logic [15:0] RCC_RESET = 16'h0003;

  // Interrupt flag status three
  localparam int unsigned POS_PWM_MATCH = 9;
  localparam logic [15:0] INTERRUPT_FLAG_STATUS_THREE_IMPL_MASK = 16'h0200;
  localparam logic [15:0] INTERRUPT_FLAG_STATUS_THREE_RESET = 16'h0000;

  // Interrupt status/mask layout
  localparam int unsigned N_EVT = 3;
  localparam int unsigned EVT_PIN = 0;
  localparam int unsigned EVT_SWR = 1;
  localparam int unsigned EVT_PWM = 2;
  localparam logic [N_EVT-1:0] EVT_ZERO = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Hardware event inputs that set flags
  typedef struct packed {
    logic pin_reset;
    logic soft_reset;
    logic wdt_timeout;
    logic woke_sleep;
    logic woke_idle;
    logic pwm_match;
  } rcf_evt_t;
endpackage
`default_nettype wire

// ### logic/rcf_axil_slave.sv
`default_nettype none
module rcf_axil_slave
  import rcf_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [1:0]             o_rresp,
  output logic [31:0]            o_rdata,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [31:0]            o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_ok,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [31:0]       i_rd_data,
  input  wire logic              i_rd_ok
);
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign o_rd_addr = i_araddr;
  assign o_wr_en = (aw_held || i_awvalid) && (w_held || i_wvalid)
                   && !o_bvalid;
  // A lone half waits in its flops; the half that completes the pair is
  // used live, so the write lands at the very edge both are taken
  assign o_wr_addr = aw_held ? aw_addr_q : i_awaddr;
  assign o_wr_data = w_held ? w_data_q : i_wdata;
  assign o_wr_strb = w_held ? w_strb_q : i_wstrb;

  // Address and data may arrive in either order; hold each until paired
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else if (o_wr_en) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held   <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (o_wr_en) begin
      o_bvalid <= 1'b1;
      o_bresp  <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= i_rd_data;
      o_rresp  <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### sim/rcf_chk_sva.sv
`default_nettype none
module rcf_chk
  import rcf_pkg::*;
(
  input  wire logic                       I_MCLK,
  input  wire logic                       I_NRST,
  input  wire logic                       I_WDT_FUSE_EN,
  input  wire logic                       O_WDT_EN,
  input  wire logic [rcf_pkg::ADDR_W-1:0] I_ARADDR,
  input  wire logic                       I_ARVALID,
  input  wire logic                       O_ARREADY,
  input  wire logic [31:0]                O_RDATA,
  input  wire logic                       O_RVALID,
  input  wire logic                       I_RREADY,
  input  wire logic                       I_AWVALID,
  input  wire logic                       O_AWREADY,
  input  wire logic                       I_WVALID,
  input  wire logic                       O_WREADY,
  input  wire logic [1:0]                 O_BRESP,
  input  wire logic                       O_BVALID,
  input  wire logic                       I_BREADY
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  sequence s_ar_take;
    I_ARVALID && O_ARREADY;
  endsequence
  sequence s_flag_rd;
    s_ar_take ##0 (I_ARADDR == INTERRUPT_FLAG_STATUS_THREE_ADDR);
  endsequence
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  a_fuse_forces_on: assert property (I_WDT_FUSE_EN |=> O_WDT_EN)
    else $error("watchdog off while fuse set");
  a_flag_unused_zero: assert property (
    s_flag_rd |=> O_RVALID && ((O_RDATA & ~32'h0000_0200) == 32'h0))
    else $error("unused flag bits read nonzero");
  a_read_answer: assert property (s_ar_take |=> O_RVALID)
    else $error("read answer late");
  a_write_answer: assert property (s_wr_take |=> O_BVALID)
    else $error("write answer late");
  a_bvalid_hold: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rvalid_hold: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_read_upper_zero: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0)
    else $error("upper read half nonzero");
  a_write_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while answering");
  a_read_busy: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while answering");
endmodule
bind rcf_top rcf_chk rcf_chk_inst (
  .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_WDT_FUSE_EN(I_WDT_FUSE_EN),
  .O_WDT_EN(O_WDT_EN), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY));
`default_nettype wire

// ### sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rcf_pkg::*;
  logic mclk, nrst, fuse, wdt_en, irq, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata;
  rcf_evt_t evt;
  int miscompares = 0;
  int n_checks = 0;
  rcf_top rcf_top_inst (
    .I_MCLK(mclk), .I_NRST(nrst), .I_EVT(evt), .I_WDT_FUSE_EN(fuse),
    .O_WDT_EN(wdt_en), .O_IRQ(irq), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RRESP(rresp),
    .O_RDATA(rdata), .O_RVALID(rvalid), .I_RREADY(rready));
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Readies come from flops, so sampling them mid-cycle predicts the edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tv, tb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      tv = bvalid;
      tb = bvalid & bready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      // Ready lags valid by a cycle to exercise the response stall
      if (tv && !tb) bready <= 1'b1;
    end while (!tb);
    bready <= 1'b0;
    chk_word({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tv, tb;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge mclk);
      ta = arready & arvalid;
      tv = rvalid;
      tb = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tv && !tb) rready <= 1'b1;
    end while (!tb);
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_word(d, exp);
    chk_word({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic pulse(input rcf_evt_t e);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    @(posedge mclk);
  endtask
  task automatic out_is(input logic got_sel, input logic exp);
    repeat (2) @(negedge mclk);
    chk_word({31'h0, got_sel ? irq : wdt_en}, {31'h0, exp});
    @(posedge mclk);
  endtask
  task automatic t_reset();
    rd_chk(4'h0, 32'h0000_0003);
    rd_chk(4'h4, 32'h0);
    rd_chk(4'h8, 32'h0);
    rd_chk(4'hc, 32'h0);
  endtask
  task automatic t_causes();
    axi_wr(4'h0, 32'h0);
    rd_chk(4'h0, 32'h0);
    pulse(6'h20);
    rd_chk(4'h0, 32'h0000_0080);
    pulse(6'h10);
    rd_chk(4'h0, 32'h0000_00c0);
    pulse(6'h0e);
    rd_chk(4'h0, 32'h0000_00dc);
  endtask
  task automatic t_soft_write();
    axi_wr(4'h0, 32'h0000_ffff);
    rd_chk(4'h0, 32'h0000_c3ff);
    out_is(1'b0, 1'b1);
    axi_wr(4'h0, 32'h0);
    out_is(1'b0, 1'b0);
    fuse <= 1'b1;
    out_is(1'b0, 1'b1);
    fuse <= 1'b0;
    out_is(1'b0, 1'b0);
  endtask
  task automatic t_flag3();
    axi_wr(4'h4, 32'h0000_ffff);
    rd_chk(4'h4, 32'h0000_0200);
    axi_wr(4'h4, 32'h0);
    rd_chk(4'h4, 32'h0);
    pulse(6'h01);
    rd_chk(4'h4, 32'h0000_0200);
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(4'h8, 32'h7);
    pulse(6'h01);
    rd_chk(4'h8, 32'h4);
    out_is(1'b1, 1'b0);
    axi_wr(4'hc, 32'h4);
    out_is(1'b1, 1'b1);
    axi_wr(4'h8, 32'h4);
    out_is(1'b1, 1'b0);
    rd_chk(4'h8, 32'h0);
    axi_rd(4'h2, d, r);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
    chk_word(d, 32'h0);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {nrst, fuse, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    evt = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_causes();
    t_soft_write();
    t_flag3();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
